// *** hdl/pprxb_pkg.sv ***
// Function
// - Compare low eight bits of each valid table entry with every received byte.
// - End-of-table flag set marks entry invalid and stops the scan.
// - Accepted match is stored, closes the buffer and raises buffer-done if enabled.
// - Rejected match goes to the holding register, raises an event, buffer stays open.
// - Compare mask bit 0 excludes that bit from the match, 1 compares it.
// - Software reads the holding register before the next rejected match overwrites it.
// - Silence count drops every 1024 clocks; reaching zero closes the open buffer.
// - A silence limit of zero disables silence closing.
// - Init command returns receiver parameters to reset values; issue while disabled.
// - Close command closes the buffer being filled; no effect when idle.
// - Byte arriving at a non-empty descriptor is dropped with a no-buffer event.
// - Device owns descriptors with empty set and clears empty when closing them, unless continuous is set.
// - After a descriptor with wrap set, continue at the table base.
// - Interrupt flag set makes a completed buffer raise the buffer-done event.
// - Control flag is one when the last byte is an accepted control character.
// - Continuous flag keeps the empty flag set after closing.
// - Silence close sets the descriptor's silence-close flag.
// - Eight-bit event register: set on events, write one clears, reset clears.
// - Interrupt request stays high while any unmasked event bit is set.
// - Events: rejected char, no buffer, byte stored, buffer completed.
package pprxb_pkg;

  // ----------------------------------------------------------------
  // Register word addresses (byte address on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CHAR0     = 8'h00;  // 8 entries, 0x00..0x1C
  localparam logic [7:0] ADDR_MASK      = 8'h20;
  localparam logic [7:0] ADDR_REJ       = 8'h24;
  localparam logic [7:0] ADDR_EVENT     = 8'h28;
  localparam logic [7:0] ADDR_EVMASK    = 8'h2C;
  localparam logic [7:0] ADDR_SILENCE   = 8'h30;
  localparam logic [7:0] ADDR_CMD       = 8'h34;
  localparam logic [7:0] ADDR_STATUS    = 8'h38;
  localparam logic [7:0] ADDR_PB_ASSIGN = 8'h3C;
  localparam logic [7:0] ADDR_PB_DIR    = 8'h40;
  localparam logic [7:0] ADDR_BUFLEN    = 8'h44;
  localparam logic [7:0] ADDR_BD0       = 8'h80;  // 8 descriptors, 0x80..0x9C

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENTRY_END_BIT = 15;
  localparam int ENTRY_REJ_BIT = 14;
  localparam int BD_EMPTY_BIT  = 15;
  localparam int BD_WRAP_BIT   = 13;
  localparam int BD_INT_BIT    = 12;
  localparam int BD_CTRL_BIT   = 11;
  localparam int BD_CONT_BIT   = 9;
  localparam int BD_SIL_BIT    = 8;
  localparam int EV_REJ_BIT    = 0;
  localparam int EV_NOBUF_BIT  = 1;
  localparam int EV_BYTE_BIT   = 2;
  localparam int EV_DONE_BIT   = 3;
  localparam int CMD_INIT_BIT  = 0;
  localparam int CMD_CLOSE_BIT = 1;
  localparam int CMD_EN_BIT    = 2;

  // ----------------------------------------------------------------
  // Sizes, reset values, timing
  // ----------------------------------------------------------------
  localparam int NUM_CHARS = 8;
  localparam int NUM_BDS   = 8;
  localparam logic [15:0] RST_ENTRY   = 16'h8000;
  localparam logic [15:0] RST_MASK    = 16'hC0FF;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [7:0]  RST_BUFLEN  = 8'h10;
  localparam logic [17:0] RST_PB      = 18'h00000;
  localparam int SILENCE_TICK_CYCLES = 1024;
  localparam logic [9:0] TICK_LAST = 10'(SILENCE_TICK_CYCLES - 1);

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pprxb_byte_t;

  typedef enum logic [1:0] {
    PPRXB_IDLE = 2'b00,
    PPRXB_FILL = 2'b01
  } pprxb_state_t;

endpackage

// *** hdl/pprxb_rx_buffering.sv ***
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module pprxb_rx_buffering
(
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire pprxb_pkg::pprxb_byte_t rx_in,
  output logic                        irq_o,
  output logic      [7:0]             buf_wr_data,
  output logic      [2:0]             buf_wr_bd,
  output logic      [7:0]             buf_wr_offset,
  output logic                        buf_wr_en,
  output logic      [17:0]            portb_assign,
  output logic      [17:0]            portb_direction
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] char_reg [pprxb_pkg::NUM_CHARS];
  logic [15:0] bd_reg [pprxb_pkg::NUM_BDS];
  logic [15:0] mask_reg;
  logic [15:0] rej_reg;
  logic [7:0]  event_reg;
  logic [7:0]  evmask_reg;
  logic [15:0] silence_limit_reg;
  logic [15:0] silence_cnt_reg;
  logic [9:0]  tick_reg;
  logic        enable_reg;
  logic [7:0]  buflen_reg;
  logic [2:0]  bd_ptr_reg;
  logic [7:0]  count_reg;
  pprxb_pkg::pprxb_state_t state_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        req;
  logic        wr;
  logic [31:0] rdata;
  logic        cmd_init;
  logic        cmd_close;

  // Ack is registered; gating with it stops one access being taken twice
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Lane 0 qualifies every write; lane 1 gates the upper byte of 16-bit registers only, port B writes take all 18 bits
  assign wr  = req && wb_we_i && wb_sel_i[0];
  // Command bits act as one-cycle pulses; only enable is kept
  assign cmd_init  = wr && (wb_adr_i == pprxb_pkg::ADDR_CMD)
                     && wb_dat_i[pprxb_pkg::CMD_INIT_BIT];
  assign cmd_close = wr && (wb_adr_i == pprxb_pkg::ADDR_CMD)
                     && wb_dat_i[pprxb_pkg::CMD_CLOSE_BIT];

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic in_table(input logic [7:0] a, input logic [7:0] base);
    in_table = (a >= base) && (a < base + 8'h20) && (a[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // Control character match, scanned in table order
  // ----------------------------------------------------------------
  logic       hit;
  logic       hit_rej;
  logic       stop;
  // First valid match wins; a later entry never overrides it
  always_comb
  begin
    hit     = 1'b0;
    hit_rej = 1'b0;
    stop    = 1'b0;
    for (int i = 0; i < pprxb_pkg::NUM_CHARS; i++)
    begin
      if (char_reg[i][pprxb_pkg::ENTRY_END_BIT])
        stop = 1'b1;
      else if (!stop && !hit &&
               (((char_reg[i][7:0] ^ rx_in.data) & mask_reg[7:0]) == 8'h00))
      begin
        hit     = 1'b1;
        hit_rej = char_reg[i][pprxb_pkg::ENTRY_REJ_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive decisions
  // ----------------------------------------------------------------
  logic [15:0] cur_bd;
  logic        bd_free;
  logic        take;
  logic        store;
  logic        tick;
  logic        sil_close;
  logic        full_close;
  logic        close_now;
  logic        ctrl_close;

  assign cur_bd  = bd_reg[bd_ptr_reg];
  assign bd_free = cur_bd[pprxb_pkg::BD_EMPTY_BIT];
  assign take    = enable_reg && rx_in.valid;
  assign store   = take && bd_free && !(hit && hit_rej);
  assign ctrl_close = store && hit;
  // Length reached; the last byte is stored in the same cycle as the close
  assign full_close = store && (count_reg + 8'h01 >= buflen_reg);
  // Free-running prescaler, so silence resolution is one tick, not one clock
  assign tick    = (tick_reg == pprxb_pkg::TICK_LAST);
  // Silence only closes an open buffer that has no byte this cycle
  assign sil_close = (state_reg == pprxb_pkg::PPRXB_FILL) && !take && tick
                     && (silence_limit_reg != 16'h0000)
                     && (silence_cnt_reg == 16'h0001);
  assign close_now = ctrl_close || full_close || sil_close
                     || (cmd_close && state_reg == pprxb_pkg::PPRXB_FILL);

  always_ff @(posedge mclk)
  begin
    if (!reset_n || cmd_init)
      tick_reg <= 10'h000;
    else if (tick)
      tick_reg <= 10'h000;
    else
      tick_reg <= tick_reg + 10'h001;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n || cmd_init)
      silence_cnt_reg <= pprxb_pkg::RST_WORD;
    else if (store || close_now)
      silence_cnt_reg <= silence_limit_reg;
    else if (state_reg == pprxb_pkg::PPRXB_FILL && tick && silence_cnt_reg != 16'h0000)
      silence_cnt_reg <= silence_cnt_reg - 16'h0001;
  end

  // ----------------------------------------------------------------
  // Receive state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n || cmd_init)
      state_reg <= pprxb_pkg::PPRXB_IDLE;
    else
    begin
      case (state_reg)
        pprxb_pkg::PPRXB_IDLE:
        begin
          if (store && !close_now)
            state_reg <= pprxb_pkg::PPRXB_FILL;
        end
        pprxb_pkg::PPRXB_FILL:
        begin
          if (close_now)
            state_reg <= pprxb_pkg::PPRXB_IDLE;
        end
        default:
          state_reg <= pprxb_pkg::PPRXB_IDLE;
      endcase
    end
  end

  // Pointer and fill count move only on closes and stores
  always_ff @(posedge mclk)
  begin
    if (!reset_n || cmd_init)
    begin
      bd_ptr_reg <= 3'h0;
      count_reg  <= 8'h00;
    end
    else if (close_now)
    begin
      count_reg <= 8'h00;
      if (cur_bd[pprxb_pkg::BD_WRAP_BIT])
        bd_ptr_reg <= 3'h0;
      else
        bd_ptr_reg <= bd_ptr_reg + 3'h1;
    end
    else if (store)
      count_reg <= count_reg + 8'h01;
  end

  // Descriptor status words; software writes and hardware closes
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < pprxb_pkg::NUM_BDS; i++)
        bd_reg[i] <= pprxb_pkg::RST_WORD;
    end
    else
    begin
      for (int i = 0; i < pprxb_pkg::NUM_BDS; i++)
        if (wr && in_table(wb_adr_i, pprxb_pkg::ADDR_BD0) && wb_adr_i[4:2] == 3'(i))
          bd_reg[i] <= merge16(bd_reg[i], wb_dat_i, wb_sel_i);
      // Hardware status wins over a software write in the same cycle
      if (close_now)
      begin
        bd_reg[bd_ptr_reg][pprxb_pkg::BD_CTRL_BIT] <= ctrl_close;
        bd_reg[bd_ptr_reg][pprxb_pkg::BD_SIL_BIT]  <= sil_close;
        if (!cur_bd[pprxb_pkg::BD_CONT_BIT])
          bd_reg[bd_ptr_reg][pprxb_pkg::BD_EMPTY_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffer write port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      buf_wr_en     <= 1'b0;
      buf_wr_data   <= 8'h00;
      buf_wr_bd     <= 3'h0;
      buf_wr_offset <= 8'h00;
    end
    else
    begin
      buf_wr_en     <= store;
      buf_wr_data   <= rx_in.data;
      buf_wr_bd     <= bd_ptr_reg;
      buf_wr_offset <= count_reg;
    end
  end

  // Each rejected match overwrites the held value; software must read it first
  always_ff @(posedge mclk)
  begin
    if (!reset_n || cmd_init)
      rej_reg <= pprxb_pkg::RST_WORD;
    else if (take && hit && hit_rej)
      rej_reg <= {8'h00, rx_in.data};
  end

  // ----------------------------------------------------------------
  // Events, set wins over clear
  // ----------------------------------------------------------------
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  always_comb
  begin
    ev_set = 8'h00;
    ev_set[pprxb_pkg::EV_REJ_BIT]   = take && hit && hit_rej;
    ev_set[pprxb_pkg::EV_NOBUF_BIT] = take && !bd_free;
    ev_set[pprxb_pkg::EV_BYTE_BIT]  = store;
    ev_set[pprxb_pkg::EV_DONE_BIT]  = close_now && cur_bd[pprxb_pkg::BD_INT_BIT];
    ev_clr = 8'h00;
    if (wr && wb_adr_i == pprxb_pkg::ADDR_EVENT)
      ev_clr = wb_dat_i[7:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      event_reg <= 8'h00;
    else
      event_reg <= (event_reg & ~ev_clr) | ev_set;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      irq_o <= 1'b0;
    else
      // Built from the next event value so the request never lags the register
      irq_o <= |(((event_reg & ~ev_clr) | ev_set) & evmask_reg);
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n || cmd_init)
    begin
      for (int i = 0; i < pprxb_pkg::NUM_CHARS; i++)
        char_reg[i] <= pprxb_pkg::RST_ENTRY;
      mask_reg          <= pprxb_pkg::RST_MASK;
      silence_limit_reg <= pprxb_pkg::RST_WORD;
      buflen_reg        <= pprxb_pkg::RST_BUFLEN;
    end
    else if (wr)
    begin
      for (int i = 0; i < pprxb_pkg::NUM_CHARS; i++)
        if (in_table(wb_adr_i, pprxb_pkg::ADDR_CHAR0) && wb_adr_i[4:2] == 3'(i))
          char_reg[i] <= merge16(char_reg[i], wb_dat_i, wb_sel_i);
      if (wb_adr_i == pprxb_pkg::ADDR_MASK)
        mask_reg <= merge16(mask_reg, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == pprxb_pkg::ADDR_SILENCE)
        silence_limit_reg <= merge16(silence_limit_reg, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == pprxb_pkg::ADDR_BUFLEN)
        buflen_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      evmask_reg      <= 8'h00;
      enable_reg      <= 1'b0;
      portb_assign    <= pprxb_pkg::RST_PB;
      portb_direction <= pprxb_pkg::RST_PB;
    end
    else if (wr)
    begin
      if (wb_adr_i == pprxb_pkg::ADDR_EVMASK)
        evmask_reg <= wb_dat_i[7:0];
      else if (wb_adr_i == pprxb_pkg::ADDR_CMD)
        enable_reg <= wb_dat_i[pprxb_pkg::CMD_EN_BIT];
      else if (wb_adr_i == pprxb_pkg::ADDR_PB_ASSIGN)
        portb_assign <= wb_dat_i[17:0];
      else if (wb_adr_i == pprxb_pkg::ADDR_PB_DIR)
        portb_direction <= wb_dat_i[17:0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux; unmapped reads return zero, every access is acked
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata = 32'h00000000;
    if (in_table(wb_adr_i, pprxb_pkg::ADDR_CHAR0))
      rdata = {16'h0000, char_reg[wb_adr_i[4:2]]};
    else if (in_table(wb_adr_i, pprxb_pkg::ADDR_BD0))
      rdata = {16'h0000, bd_reg[wb_adr_i[4:2]]};
    else if (wb_adr_i == pprxb_pkg::ADDR_MASK)
      rdata = {16'h0000, mask_reg};
    else if (wb_adr_i == pprxb_pkg::ADDR_REJ)
      rdata = {16'h0000, rej_reg};
    else if (wb_adr_i == pprxb_pkg::ADDR_EVENT)
      rdata = {24'h000000, event_reg};
    else if (wb_adr_i == pprxb_pkg::ADDR_EVMASK)
      rdata = {24'h000000, evmask_reg};
    else if (wb_adr_i == pprxb_pkg::ADDR_SILENCE)
      rdata = {16'h0000, silence_limit_reg};
    else if (wb_adr_i == pprxb_pkg::ADDR_CMD)
      rdata = {29'h00000000, enable_reg, 2'b00};
    else if (wb_adr_i == pprxb_pkg::ADDR_STATUS)
      rdata = {13'h0000, bd_ptr_reg, count_reg, silence_cnt_reg[6:0], state_reg[0]};
    else if (wb_adr_i == pprxb_pkg::ADDR_PB_ASSIGN)
      rdata = {14'h0000, portb_assign};
    else if (wb_adr_i == pprxb_pkg::ADDR_PB_DIR)
      rdata = {14'h0000, portb_direction};
    else if (wb_adr_i == pprxb_pkg::ADDR_BUFLEN)
      rdata = {24'h000000, buflen_reg};
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= rdata;
    end
  end

endmodule

// *** sim/pprxb_host_model.sv ***
`timescale 1ns/1ps
module pprxb_host_model
(
  input wire logic              mclk,
  output pprxb_pkg::pprxb_byte_t rx_in
);
  initial rx_in = '0;
  // Released data shows the inverse so a stale byte never looks fresh
  task automatic send(input logic [7:0] d);
    @(posedge mclk);
    rx_in <= '{valid: 1'b1, data: d};
    @(posedge mclk);
    rx_in <= '{valid: 1'b0, data: ~d};
  endtask
  // Two bytes on consecutive edges, the fastest the receiver must accept
  task automatic send_pair(input logic [7:0] d0, input logic [7:0] d1);
    @(posedge mclk);
    rx_in <= '{valid: 1'b1, data: d0};
    @(posedge mclk);
    rx_in <= '{valid: 1'b1, data: d1};
    @(posedge mclk);
    rx_in <= '{valid: 1'b0, data: ~d1};
  endtask
endmodule

// *** sim/pprxb_monitor.sv ***
`timescale 1ns/1ps
module pprxb_monitor
(
  input wire logic                   mclk,
  input wire logic                   reset_n,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [7:0]             wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire pprxb_pkg::pprxb_byte_t rx_in,
  input wire logic                   irq_o,
  input wire logic [7:0]             buf_wr_data,
  input wire logic [2:0]             buf_wr_bd,
  input wire logic [7:0]             buf_wr_offset,
  input wire logic                   buf_wr_en,
  input wire logic [17:0]            portb_assign,
  input wire logic [17:0]            portb_direction
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  ack_one_cycle_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_latency_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_no_request_a:
    assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack unasked");
  read_upper_zero_a:
    assert property (wb_ack_o |-> wb_dat_o[31:19] == 13'h0000) else $error("upper bits set");
  portb_by_write_a:
    assert property (!$stable(portb_assign) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
      else $error("port assign changed without write");
  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  write_has_byte_a:
    assert property (buf_wr_en |-> $past(rx_in.valid) && buf_wr_data == $past(rx_in.data))
      else $error("buffer write without matching byte");
  offset_steps_a:
    assert property (buf_wr_en && $past(buf_wr_en) && buf_wr_offset != 8'h00
                     |-> buf_wr_offset == $past(buf_wr_offset) + 8'h01)
      else $error("offset not incremented");
  irq_clear_write_a:
    assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
      else $error("irq dropped without write");
endmodule

// *** sim/pprxb_rx_buffering_test.sv ***
`timescale 1ns/1ps
module pprxb_rx_buffering_test;
  logic                   mclk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic                   irq_o, buf_wr_en;
  logic [7:0]             wb_adr_i, buf_wr_data, buf_wr_offset, last_data, last_off;
  logic [3:0]             wb_sel_i;
  logic [31:0]            wb_dat_i, wb_dat_o, q;
  logic [2:0]             buf_wr_bd, last_bd;
  logic [17:0]            portb_assign, portb_direction;
  pprxb_pkg::pprxb_byte_t rx_in;
  int                     num_errors, total_checks, wr_count;

  pprxb_rx_buffering dut (.*);
  pprxb_host_model host (.mclk(mclk), .rx_in(rx_in));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (buf_wr_en === 1'b1)
    begin
      wr_count++;
      last_data = buf_wr_data;
      last_off = buf_wr_offset;
      last_bd = buf_wr_bd;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Wait for ack without assuming latency; only the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(n, e, q & m);
  endtask
  task automatic byte_in(input logic [7:0] d);
    host.send(d);
    repeat (2) @(posedge mclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd("mask", pprxb_pkg::ADDR_MASK, 32'hFFFF, 32'hC0FF);
    rd("entry", pprxb_pkg::ADDR_CHAR0, 32'hFFFF, 32'h8000);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hFF, 32'h00);
    rd("unmapped", 8'h60, 32'hFFFFFFFF, 32'h0);
    $display("done reset");
  endtask
  task automatic t_setup();
    wr(pprxb_pkg::ADDR_PB_ASSIGN, 32'h3FFFF);
    rd("assign", pprxb_pkg::ADDR_PB_ASSIGN, 32'hFFFFFFFF, 32'h3FFFF);
    wr(pprxb_pkg::ADDR_PB_ASSIGN, 32'h0);
    wr(pprxb_pkg::ADDR_PB_DIR, 32'h2AAAA);
    rd("dir", pprxb_pkg::ADDR_PB_DIR, 32'hFFFFFFFF, 32'h2AAAA);
    wr(pprxb_pkg::ADDR_EVMASK, 32'hF);
    wr(pprxb_pkg::ADDR_MASK, 32'hC0FE);
    wr(8'h00, 32'h0041);
    wr(8'h04, 32'h4042);
    wr(8'h08, 32'h8000);
    wr(8'h0C, 32'h0044);
    wr(pprxb_pkg::ADDR_BD0, 32'hB000);
    wr(pprxb_pkg::ADDR_CMD, 32'h4);
    $display("done setup");
  endtask
  task automatic t_stream();
    byte_in(8'h10);
    byte_in(8'h44);
    chk("writes", 2, wr_count);
    chk("data", 32'h44, last_data);
    chk("offset", 32'h1, last_off);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hF, 32'h4);
    $display("done stream");
  endtask
  task automatic t_reject();
    byte_in(8'h43);
    chk("writes", 2, wr_count);
    rd("held", pprxb_pkg::ADDR_REJ, 32'hFFFF, 32'h43);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hF, 32'h5);
    chk("irq", 1, irq_o);
    wr(pprxb_pkg::ADDR_EVENT, 32'h1);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hF, 32'h4);
    chk("irq", 1, irq_o);
    wr(pprxb_pkg::ADDR_EVENT, 32'h4);
    repeat (2) @(posedge mclk);
    chk("irq", 0, irq_o);
    $display("done reject");
  endtask
  task automatic t_accept();
    byte_in(8'h41);
    chk("writes", 3, wr_count);
    chk("data", 32'h41, last_data);
    rd("desc", pprxb_pkg::ADDR_BD0, 32'hBB00, 32'h3800);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hF, 32'hC);
    wr(pprxb_pkg::ADDR_EVENT, 32'hF);
    byte_in(8'h20);
    chk("writes", 3, wr_count);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hF, 32'h2);
    wr(pprxb_pkg::ADDR_BD0, 32'hB200);
    byte_in(8'h21);
    chk("writes", 4, wr_count);
    chk("offset", 32'h0, last_off);
    chk("bd", 32'h0, last_bd);
    wr(pprxb_pkg::ADDR_EVENT, 32'hF);
    $display("done accept");
  endtask
  task automatic t_close();
    wr(pprxb_pkg::ADDR_CMD, 32'h6);
    rd("desc", pprxb_pkg::ADDR_BD0, 32'hBB00, 32'hB200);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hF, 32'h8);
    wr(pprxb_pkg::ADDR_EVENT, 32'hF);
    wr(pprxb_pkg::ADDR_CMD, 32'h6);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hF, 32'h0);
    $display("done close");
  endtask
  task automatic t_silence();
    wr(pprxb_pkg::ADDR_SILENCE, 32'h2);
    byte_in(8'h22);
    repeat (1000) @(posedge mclk);
    rd("filling", pprxb_pkg::ADDR_STATUS, 32'h1, 32'h1);
    repeat (1100) @(posedge mclk);
    rd("desc", pprxb_pkg::ADDR_BD0, 32'hBB00, 32'hB300);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hF, 32'hC);
    wr(pprxb_pkg::ADDR_SILENCE, 32'h0);
    wr(pprxb_pkg::ADDR_EVENT, 32'hF);
    host.send_pair(8'h23, 8'h24);
    repeat (2) @(posedge mclk);
    chk("offset", 32'h1, last_off);
    repeat (2100) @(posedge mclk);
    rd("filling", pprxb_pkg::ADDR_STATUS, 32'h1, 32'h1);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hF, 32'h4);
    $display("done silence");
  endtask
  task automatic t_init();
    wr(pprxb_pkg::ADDR_EVENT, 32'hF);
    wr(pprxb_pkg::ADDR_BUFLEN, 32'h3);
    byte_in(8'h25);
    rd("events", pprxb_pkg::ADDR_EVENT, 32'hF, 32'hC);
    rd("desc", pprxb_pkg::ADDR_BD0, 32'hBB00, 32'hB200);
    wr(pprxb_pkg::ADDR_CMD, 32'h0);
    wr(pprxb_pkg::ADDR_CMD, 32'h1);
    rd("buflen", pprxb_pkg::ADDR_BUFLEN, 32'hFF, 32'h10);
    rd("mask", pprxb_pkg::ADDR_MASK, 32'hFFFF, 32'hC0FF);
    rd("entry", pprxb_pkg::ADDR_CHAR0, 32'hFFFF, 32'h8000);
    $display("done init");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_setup();
    t_stream();
    t_reject();
    t_accept();
    t_close();
    t_silence();
    t_init();
    tally_and_finish();
  end

  // Run needs about 5000 cycles; allow four times that
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    tally_and_finish();
  end
endmodule

bind pprxb_rx_buffering pprxb_monitor mon (.*);
